// File: logic/scp_defs.svh
// Register map, field masks, reset values and counts of the serial configuration port
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

`define SCP_ADDR_PORT_CFG 13'h0000
`define SCP_ADDR_CHIP_ID 13'h0001
`define SCP_ADDR_CHAN_SEL 13'h0005
`define SCP_ADDR_PWR_MODE 13'h0008
`define SCP_ADDR_CLK_CFG 13'h0009
`define SCP_ADDR_OUT_MODE 13'h0014

`define SCP_RST_PORT_CFG 8'h18
`define SCP_RST_CHAN_SEL 8'h03
`define SCP_RST_PWR_MODE 8'h00
`define SCP_RST_CLK_CFG 8'h01
`define SCP_RST_OUT_MODE 8'h00

`define SCP_MASK_LSB 8'h42
`define SCP_MASK_SRST 8'h24
`define SCP_MASK_CHAN_SEL 8'h03
`define SCP_MASK_PWR_MODE 8'h23
`define SCP_MASK_CLK_CFG 8'h01
`define SCP_MASK_OUT_MODE 8'h03

`define SCP_BIT_LSB 1
`define SCP_BIT_READ 7
`define SCP_BIT_PIN_STANDBY 5
`define SCP_BIT_DCS 0

`define SCP_LEN_STREAM 2'h3
`define SCP_FMT_TWOS 2'h1
`define SCP_PWR_FULL 2'h1
`define SCP_PWR_STANDBY 2'h2
`define SCP_STRAP_SETTLE 2'h3

`endif

// File: logic/scp_pkg.sv
// Types shared by the serial configuration port
`default_nettype none
package scp_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_INSTR_HI = 2'b01,
        PH_INSTR_LO = 2'b10,
        PH_DATA = 2'b11
    } scp_phase_t;
endpackage
`default_nettype wire

// File: logic/scp_sync.sv
// Two-flop level synchroniser
`default_nettype none
module scp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

// File: logic/scp_pulse_xfer.sv
// Toggle to one-cycle pulse crossing
`default_nettype none
module scp_pulse_xfer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tog,
    output logic pulse
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= tog;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign pulse = sync_q ^ last_q;
endmodule
`default_nettype wire

// File: logic/scp_top.sv
// Serial configuration port with pin straps, top level
`include "scp_defs.svh"
`default_nettype none
module scp_top #(
    parameter logic [7:0] CHIP_ID = 8'hA5  // Arbitrary identification value
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serialClockFormatPin,
    input wire logic portSelectN,
    input wire logic serialIoStabilizerPinIn,
    output logic serialIoStabilizerPinOut,
    output logic serialIoStabilizerPinOe,
    input wire logic outputEnableNPin,
    input wire logic powerOffPin,
    output logic stabilizerEn,
    output logic twosComplement,
    output logic dataOutEn,
    output logic [1:0] chanPowerDown,
    output logic [1:0] chanStandby
);
    import scp_pkg::*;

    // Serial clock domain, byte level
    logic byteRst;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d;
    logic stalled_q, stalled_d;
    // Serial clock domain, frame level
    scp_phase_t phase_q, phase_d, curPhase;
    logic inByte_q, inByte_d;
    logic [7:0] instrA_q, instrA_d;
    logic readOp_q, readOp_d;
    logic [1:0] lenCode_q, lenCode_d;
    logic [1:0] wordCnt_q, wordCnt_d;
    logic [12:0] addr_q, addr_d;
    logic [12:0] wrAddr_q, wrAddr_d;
    logic [7:0] wrData_q, wrData_d;
    logic wrTog_q, wrTog_d;
    logic lsbS_q, lsbS_d;
    logic byteDone;
    logic startNew;
    logic [7:0] instrHi, instrLo;
    // Serial clock domain, drive side
    logic sdioOut_q, sdioOut_d;
    logic sdioOe_q, sdioOe_d;
    logic [7:0] rdByte;
    // System clock domain
    logic [4:0] pinS;
    logic selS, sdioS, sclkS, oebS, pdwnS;
    logic wrPulse;
    logic [7:0] portCfg_q, portCfg_d;
    logic [7:0] chanSel_q, chanSel_d;
    logic [7:0] pwrMode_q [2];
    logic [7:0] pwrMode_d [2];
    logic [7:0] clkCfg_q, clkCfg_d;
    logic [7:0] outMode_q, outMode_d;
    logic serialUsed_q, serialUsed_d;
    logic [1:0] settle_q, settle_d;
    logic strapDone_q, strapDone_d;
    logic strapDcs_q, strapDcs_d;
    logic strapDfs_q, strapDfs_d;
    logic stabEn_q, stabEn_d;
    logic twos_q, twos_d;
    logic outEn_q, outEn_d;
    logic [1:0] pd_q, pd_d;
    logic [1:0] sb_q, sb_d;

    // Select high holds the byte counter clear and releases the pin
    assign byteRst = portSelectN | sys_rst;

    assign byteDone = (bitCnt_q == 3'h7);

    // Byte-level next state: shift in on every rising serial clock
    always_comb begin
        bitCnt_d = bitCnt_q + 3'h1;
        stalled_d = 1'b0;
        if (lsbS_q) begin
            shift_d = {serialIoStabilizerPinIn, shift_q[7:1]};
        end else begin
            shift_d = {shift_q[6:0], serialIoStabilizerPinIn};
        end
    end

    always_ff @(posedge serialClockFormatPin or posedge byteRst) begin
        if (byteRst) begin
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            stalled_q <= 1'b1;
        end else begin
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            stalled_q <= stalled_d;
        end
    end

    // A select rise mid-byte or in a streaming frame ends the frame
    assign startNew = (phase_q == PH_IDLE)
        || (stalled_q && (inByte_q || lenCode_q == `SCP_LEN_STREAM));

    assign instrHi = lsbS_q ? shift_d : instrA_q;
    assign instrLo = lsbS_q ? instrA_q : shift_d;

    // Frame-level next state
    always_comb begin
        phase_d = phase_q;
        inByte_d = inByte_q;
        instrA_d = instrA_q;
        readOp_d = readOp_q;
        lenCode_d = lenCode_q;
        wordCnt_d = wordCnt_q;
        addr_d = addr_q;
        wrAddr_d = wrAddr_q;
        wrData_d = wrData_q;
        wrTog_d = wrTog_q;
        lsbS_d = lsbS_q;
        curPhase = startNew ? PH_INSTR_HI : phase_q;
        if (!portSelectN) begin
            phase_d = curPhase;
            inByte_d = !byteDone;
            if (byteDone) begin
                if (curPhase == PH_INSTR_HI) begin
                    instrA_d = shift_d;
                    phase_d = PH_INSTR_LO;
                end else if (curPhase == PH_INSTR_LO) begin
                    readOp_d = instrHi[`SCP_BIT_READ];
                    lenCode_d = instrHi[6:5];
                    addr_d = {instrHi[4:0], instrLo};
                    wordCnt_d = 2'h0;
                    phase_d = PH_DATA;
                end else begin
                    if (!readOp_q) begin
                        wrAddr_d = addr_q;
                        wrData_d = shift_d;
                        wrTog_d = !wrTog_q;
                        // Order flips here, so the next frame needs no idle edges
                        if (addr_q == `SCP_ADDR_PORT_CFG) begin
                            lsbS_d = !(|(shift_d & `SCP_MASK_SRST))
                                && |(shift_d & `SCP_MASK_LSB);
                        end
                    end
                    addr_d = lsbS_q ? addr_q + 13'h0001 : addr_q - 13'h0001;
                    wordCnt_d = wordCnt_q + 2'h1;
                    if (lenCode_q != `SCP_LEN_STREAM && wordCnt_q == lenCode_q) begin
                        phase_d = PH_IDLE;
                    end
                end
            end
        end
    end

    always_ff @(posedge serialClockFormatPin or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= PH_IDLE;
            inByte_q <= 1'b0;
            instrA_q <= 8'h00;
            readOp_q <= 1'b0;
            lenCode_q <= 2'h0;
            wordCnt_q <= 2'h0;
            addr_q <= 13'h0000;
            wrAddr_q <= 13'h0000;
            wrData_q <= 8'h00;
            wrTog_q <= 1'b0;
            lsbS_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            inByte_q <= inByte_d;
            instrA_q <= instrA_d;
            readOp_q <= readOp_d;
            lenCode_q <= lenCode_d;
            wordCnt_q <= wordCnt_d;
            addr_q <= addr_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
            wrTog_q <= wrTog_d;
            lsbS_q <= lsbS_d;
        end
    end

    // Readback source; register contents only move after a completed write
    always_comb begin
        rdByte = 8'h00;
        if (addr_q == `SCP_ADDR_PORT_CFG) begin
            rdByte = portCfg_q;
        end else if (addr_q == `SCP_ADDR_CHIP_ID) begin
            rdByte = CHIP_ID;
        end else if (addr_q == `SCP_ADDR_CHAN_SEL) begin
            rdByte = chanSel_q;
        end else if (addr_q == `SCP_ADDR_PWR_MODE) begin
            rdByte = pwrMode_q[!chanSel_q[0]];
        end else if (addr_q == `SCP_ADDR_CLK_CFG) begin
            rdByte = clkCfg_q;
        end else if (addr_q == `SCP_ADDR_OUT_MODE) begin
            rdByte = outMode_q;
        end
    end

    // Drive side on the falling serial clock
    always_comb begin
        sdioOe_d = (phase_q == PH_DATA) && readOp_q;
        sdioOut_d = rdByte[lsbS_q ? bitCnt_q : ~bitCnt_q];
    end

    always_ff @(negedge serialClockFormatPin or posedge byteRst) begin
        if (byteRst) begin
            sdioOut_q <= 1'b0;
            sdioOe_q <= 1'b0;
        end else begin
            sdioOut_q <= sdioOut_d;
            sdioOe_q <= sdioOe_d;
        end
    end

    assign serialIoStabilizerPinOut = sdioOut_q;
    assign serialIoStabilizerPinOe = sdioOe_q;

    // System clock side: pin levels and write events
    scp_sync #(
        .WIDTH(5)
    ) pinSync (
        .clk(mclk),
        .rst(sys_rst),
        .din({portSelectN, serialIoStabilizerPinIn, serialClockFormatPin,
              outputEnableNPin, powerOffPin}),
        .dout(pinS)
    );

    assign {selS, sdioS, sclkS, oebS, pdwnS} = pinS;

    scp_pulse_xfer wrXfer (
        .clk(mclk),
        .rst(sys_rst),
        .tog(wrTog_q),
        .pulse(wrPulse)
    );

    // Register file; write address and data are held stable by the toggle
    always_comb begin
        portCfg_d = portCfg_q;
        chanSel_d = chanSel_q;
        pwrMode_d = pwrMode_q;
        clkCfg_d = clkCfg_q;
        outMode_d = outMode_q;
        serialUsed_d = serialUsed_q | wrPulse;
        if (wrPulse) begin
            if (wrAddr_q == `SCP_ADDR_PORT_CFG) begin
                if (|(wrData_q & `SCP_MASK_SRST)) begin
                    portCfg_d = `SCP_RST_PORT_CFG;
                    chanSel_d = `SCP_RST_CHAN_SEL;
                    pwrMode_d[0] = `SCP_RST_PWR_MODE;
                    pwrMode_d[1] = `SCP_RST_PWR_MODE;
                    clkCfg_d = `SCP_RST_CLK_CFG;
                    outMode_d = `SCP_RST_OUT_MODE;
                end else begin
                    portCfg_d = `SCP_RST_PORT_CFG
                        | ({8{|(wrData_q & `SCP_MASK_LSB)}} & `SCP_MASK_LSB);
                end
            end else if (wrAddr_q == `SCP_ADDR_CHAN_SEL) begin
                chanSel_d = wrData_q & `SCP_MASK_CHAN_SEL;
            end else if (wrAddr_q == `SCP_ADDR_PWR_MODE) begin
                for (int c = 0; c < 2; c++) begin
                    if (chanSel_q[c]) begin
                        pwrMode_d[c] = wrData_q & `SCP_MASK_PWR_MODE;
                    end
                end
            end else if (wrAddr_q == `SCP_ADDR_CLK_CFG) begin
                clkCfg_d = wrData_q & `SCP_MASK_CLK_CFG;
            end else if (wrAddr_q == `SCP_ADDR_OUT_MODE) begin
                outMode_d = wrData_q & `SCP_MASK_OUT_MODE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            portCfg_q <= `SCP_RST_PORT_CFG;
            chanSel_q <= `SCP_RST_CHAN_SEL;
            pwrMode_q[0] <= `SCP_RST_PWR_MODE;
            pwrMode_q[1] <= `SCP_RST_PWR_MODE;
            clkCfg_q <= `SCP_RST_CLK_CFG;
            outMode_q <= `SCP_RST_OUT_MODE;
            serialUsed_q <= 1'b0;
        end else begin
            portCfg_q <= portCfg_d;
            chanSel_q <= chanSel_d;
            pwrMode_q <= pwrMode_d;
            clkCfg_q <= clkCfg_d;
            outMode_q <= outMode_d;
            serialUsed_q <= serialUsed_d;
        end
    end

    // Strap capture once the synchronised pins have settled after reset
    always_comb begin
        settle_d = settle_q;
        strapDone_d = strapDone_q;
        strapDcs_d = strapDcs_q;
        strapDfs_d = strapDfs_q;
        if (!strapDone_q) begin
            settle_d = settle_q + 2'h1;
            if (settle_q == `SCP_STRAP_SETTLE) begin
                strapDone_d = 1'b1;
                if (selS) begin
                    strapDcs_d = sdioS;
                    strapDfs_d = sclkS;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            settle_q <= 2'h0;
            strapDone_q <= 1'b0;
            strapDcs_q <= 1'b1;
            strapDfs_q <= 1'b0;
        end else begin
            settle_q <= settle_d;
            strapDone_q <= strapDone_d;
            strapDcs_q <= strapDcs_d;
            strapDfs_q <= strapDfs_d;
        end
    end

    // Per-channel power state from pin and register
    for (genvar c = 0; c < 2; c++) begin : gChan
        assign pd_d[c] = (pdwnS && !pwrMode_q[c][`SCP_BIT_PIN_STANDBY])
            || (pwrMode_q[c][1:0] == `SCP_PWR_FULL);
        assign sb_d[c] = (pdwnS && pwrMode_q[c][`SCP_BIT_PIN_STANDBY])
            || (pwrMode_q[c][1:0] == `SCP_PWR_STANDBY);
    end

    // Straps rule until the first register write arrives
    always_comb begin
        stabEn_d = serialUsed_q ? clkCfg_q[`SCP_BIT_DCS] : strapDcs_q;
        twos_d = serialUsed_q ? (outMode_q[1:0] == `SCP_FMT_TWOS) : strapDfs_q;
        outEn_d = !oebS;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stabEn_q <= 1'b1;
            twos_q <= 1'b0;
            outEn_q <= 1'b0;
            pd_q <= 2'h0;
            sb_q <= 2'h0;
        end else begin
            stabEn_q <= stabEn_d;
            twos_q <= twos_d;
            outEn_q <= outEn_d;
            pd_q <= pd_d;
            sb_q <= sb_d;
        end
    end

    assign stabilizerEn = stabEn_q;
    assign twosComplement = twos_q;
    assign dataOutEn = outEn_q;
    assign chanPowerDown = pd_q;
    assign chanStandby = sb_q;
endmodule
`default_nettype wire

// File: tb/scp_host.sv
// Host model: drives serial frames, strap levels and the shared data line
`default_nettype none
module scp_host (
    output logic sclk,
    output logic csN,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic dataLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hostOe = 1'b1;
    logic hostDat = 1'b0;
    logic lsbMode = 1'b0;
    initial begin
        sclk = 1'b1;
        csN = 1'b1;
    end
    // Undriven line shows the inverse of the last host value
    assign dataLine = pinOe ? pinOut : (hostOe ? hostDat : !hostDat);

    task automatic setOrder(input logic lsb);
        lsbMode = lsb;
    endtask

    task automatic serialMode();
        sclk = 1'b0;
    endtask

    // Data set after a fall, taken on the rise
    task automatic shift(input logic [7:0] b, input logic drive, input int n,
        output logic [7:0] got);
        int k;
        got = 8'h00;
        for (int i = 0; i < n; i++) begin
            k = lsbMode ? i : 7 - i;
            hostOe = drive;
            hostDat = b[k];
            #15 sclk = 1'b1;
            got[k] = dataLine;
            #15 sclk = 1'b0;
        end
    endtask

    task automatic stall();
        csN = 1'b1;
        #90 csN = 1'b0;
        #15;
    endtask

    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr,
        input logic [23:0] wd, input int nw, input int stallAt, output logic [23:0] rdat);
        logic [7:0] ins [2];
        logic [7:0] got;
        ins[0] = {rd, len, addr[12:8]};
        ins[1] = addr[7:0];
        rdat = 24'h0;
        csN = 1'b0;
        #15;
        for (int j = 0; j < 2; j++) shift(ins[lsbMode ? 1 - j : j], 1'b1, 8, got);
        for (int w = 0; w < nw; w++) begin
            if (w == stallAt) stall();
            shift(wd[23 - 8 * w -: 8], !rd, 8, got);
            rdat[23 - 8 * w -: 8] = got;
        end
        #15 csN = 1'b1;
        hostOe = 1'b0;
        #90;
    endtask

    task automatic abortFrame();
        logic [7:0] g;
        csN = 1'b0;
        #15;
        shift(8'hFF, 1'b1, 5, g);
        #15 csN = 1'b1;
        #90;
    endtask
endmodule
`default_nettype wire

// File: tb/scp_top_sva.sv
// Assertions on the serial configuration port pins
`default_nettype none
module scp_top_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serialClockFormatPin,
    input wire logic portSelectN,
    input wire logic serialIoStabilizerPinIn,
    input wire logic serialIoStabilizerPinOut,
    input wire logic serialIoStabilizerPinOe,
    input wire logic outputEnableNPin,
    input wire logic powerOffPin,
    input wire logic stabilizerEn,
    input wire logic twosComplement,
    input wire logic dataOutEn,
    input wire logic [1:0] chanPowerDown,
    input wire logic [1:0] chanStandby
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] edgeCnt_q;
    logic [7:0] edgeCnt_d;
    always_comb begin
        edgeCnt_d = (edgeCnt_q == 8'hFF) ? edgeCnt_q : edgeCnt_q + 8'h01;
    end
    always_ff @(posedge serialClockFormatPin or posedge portSelectN) begin
        if (portSelectN) begin
            edgeCnt_q <= 8'h00;
        end else begin
            edgeCnt_q <= edgeCnt_d;
        end
    end
    sequence s_readStart;
        $rose(serialIoStabilizerPinOe);
    endsequence
    property p_oe_start;
        @(posedge serialClockFormatPin) disable iff (sys_rst || portSelectN)
        s_readStart |-> edgeCnt_q == 8'h10;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("drive began off the 16th bit");
    property p_oe_run;
        @(posedge serialClockFormatPin) disable iff (sys_rst || portSelectN)
        s_readStart |-> serialIoStabilizerPinOe [*8];
    endproperty
    a_oe_run: assert property (p_oe_run) else $error("readback word cut short");
    property p_oe_quiet;
        @(posedge serialClockFormatPin) disable iff (sys_rst || portSelectN)
        edgeCnt_q < 8'h10 |-> !serialIoStabilizerPinOe;
    endproperty
    a_oe_quiet: assert property (p_oe_quiet) else $error("drive during instruction");
    property p_oe_sel;
        @(posedge mclk) disable iff (sys_rst)
        portSelectN |-> !serialIoStabilizerPinOe;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("data pin driven while deselected");
    property p_rst_vals;
        @(posedge mclk) disable iff (sys_rst)
        $fell(sys_rst) |-> stabilizerEn && !twosComplement && !dataOutEn
            && chanPowerDown == 2'h0 && chanStandby == 2'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not at defaults");
    property p_oen_hi;
        @(posedge mclk) disable iff (sys_rst)
        outputEnableNPin [*7] |-> !dataOutEn;
    endproperty
    a_oen_hi: assert property (p_oen_hi) else $error("outputs enabled with pin high");
    property p_oen_lo;
        @(posedge mclk) disable iff (sys_rst)
        !outputEnableNPin [*7] |-> dataOutEn;
    endproperty
    a_oen_lo: assert property (p_oen_lo) else $error("outputs off with pin low");
    property p_pwr_pin;
        @(posedge mclk) disable iff (sys_rst)
        powerOffPin [*7] |-> (chanPowerDown | chanStandby) == 2'h3;
    endproperty
    a_pwr_pin: assert property (p_pwr_pin) else $error("power pin ignored");
endmodule
bind scp_top scp_top_sva scp_top_sva_inst (.mclk(mclk), .sys_rst(sys_rst),
    .serialClockFormatPin(serialClockFormatPin), .portSelectN(portSelectN),
    .serialIoStabilizerPinIn(serialIoStabilizerPinIn),
    .serialIoStabilizerPinOut(serialIoStabilizerPinOut),
    .serialIoStabilizerPinOe(serialIoStabilizerPinOe), .outputEnableNPin(outputEnableNPin),
    .powerOffPin(powerOffPin), .stabilizerEn(stabilizerEn), .twosComplement(twosComplement),
    .dataOutEn(dataOutEn), .chanPowerDown(chanPowerDown), .chanStandby(chanStandby));
`default_nettype wire

// File: tb/scp_top_bench.sv
// Self-checking bench for the serial configuration port
`default_nettype none
module scp_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic oenPin = 1'b0;
    logic pwrPin = 1'b0;
    logic sclk, csN, dataLine, pinOut, pinOe, stabEn, twos, outEn;
    logic [1:0] chanPd, chanSb;
    logic [23:0] rd;
    int badCount = 0;
    int samplesChecked = 0;
    always #10 mclk = ~mclk;

    scp_top scp_top_inst (.mclk(mclk), .sys_rst(sysRst), .serialClockFormatPin(sclk),
        .portSelectN(csN), .serialIoStabilizerPinIn(dataLine),
        .serialIoStabilizerPinOut(pinOut), .serialIoStabilizerPinOe(pinOe),
        .outputEnableNPin(oenPin), .powerOffPin(pwrPin), .stabilizerEn(stabEn),
        .twosComplement(twos), .dataOutEn(outEn), .chanPowerDown(chanPd), .chanStandby(chanSb));
    scp_host scp_host_inst (.sclk(sclk), .csN(csN), .pinOut(pinOut), .pinOe(pinOe),
        .dataLine(dataLine));

    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic waitClk(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic regWr(input logic [12:0] a, input logic [7:0] d);
        scp_host_inst.frame(1'b0, 2'h0, a, {d, 16'h0}, 1, -1, rd);
    endtask

    task automatic regRd(input logic [12:0] a, input logic [7:0] exp);
        scp_host_inst.frame(1'b1, 2'h0, a, 24'h0, 1, -1, rd);
        check(rd[23:16], exp, "register read");
    endtask

    task automatic tStrap();
        waitClk(10);
        check({6'h0, stabEn, twos}, 8'h01, "strap levels");
        check({7'h0, pinOe}, 8'h00, "data pin released");
        scp_host_inst.serialMode();
        $display("test strap done");
    endtask

    task automatic tPins();
        oenPin <= 1'b1;
        pwrPin <= 1'b1;
        waitClk(8);
        check({3'h0, outEn, chanPd, chanSb}, 8'h0C, "pins high");
        oenPin <= 1'b0;
        pwrPin <= 1'b0;
        waitClk(8);
        check({3'h0, outEn, chanPd, chanSb}, 8'h10, "pins low");
        $display("test pins done");
    endtask

    task automatic tDefaults();
        regRd(13'h0000, 8'h18);
        regRd(13'h0005, 8'h03);
        regRd(13'h0009, 8'h01);
        regRd(13'h0013, 8'h00);
        $display("test defaults done");
    endtask

    task automatic tWords();
        scp_host_inst.frame(1'b0, 2'h0, 13'h0014, 24'h010000, 1, -1, rd);
        scp_host_inst.frame(1'b0, 2'h1, 13'h0009, 24'h010100, 2, -1, rd);
        waitClk(6);
        check({6'h0, stabEn, twos}, 8'h03, "register overrides strap");
        check({6'h0, chanPd}, 8'h03, "full power down");
        scp_host_inst.frame(1'b1, 2'h2, 13'h0009, 24'h0, 3, -1, rd);
        check(rd[23:16], 8'h01, "word one");
        check(rd[15:8], 8'h01, "word two");
        check(rd[7:0], 8'h00, "word three");
        scp_host_inst.frame(1'b1, 2'h3, 13'h0005, 24'h0, 2, -1, rd);
        check(rd[23:16], 8'h03, "stream one");
        check(rd[15:8], 8'h00, "stream two");
        $display("test words done");
    endtask

    task automatic tLocal();
        regWr(13'h0005, 8'h01);
        regWr(13'h0008, 8'h00);
        waitClk(6);
        check({6'h0, chanPd}, 8'h02, "local write reaches A only");
        regWr(13'h0008, 8'h02);
        waitClk(6);
        check({4'h0, chanPd, chanSb}, 8'h09, "standby on A only");
        regWr(13'h0005, 8'h03);
        regRd(13'h0008, 8'h02);
        $display("test local done");
    endtask

    task automatic tStall();
        scp_host_inst.frame(1'b0, 2'h0, 13'h0005, 24'h020000, 1, 0, rd);
        regRd(13'h0005, 8'h02);
        scp_host_inst.abortFrame();
        regRd(13'h0005, 8'h02);
        $display("test stall done");
    endtask

    task automatic tOrder();
        regWr(13'h0000, 8'h42);
        scp_host_inst.setOrder(1'b1);
        regRd(13'h0005, 8'h02);
        regWr(13'h0000, 8'h00);
        scp_host_inst.setOrder(1'b0);
        regRd(13'h0000, 8'h18);
        $display("test order done");
    endtask

    task automatic tReset();
        sysRst <= 1'b1;
        waitClk(6);
        sysRst <= 1'b0;
        waitClk(10);
        regRd(13'h0005, 8'h03);
        $display("test reset done");
    endtask

    initial begin
        #300us;
        badCount++;
        conclude();
    end

    initial begin
        waitClk(6);
        sysRst <= 1'b0;
        tStrap();
        tPins();
        tDefaults();
        tWords();
        tLocal();
        tStall();
        tOrder();
        @(posedge mclk);
        tReset();
        conclude();
    end
endmodule
`default_nettype wire
